// file: core/fbm_top.sv
// How it works
// RL1: Each buffer holds up to 1K words for one exchange.
// RL2: Handshaked buffers answer received data; free-format ones never answer.
// RL3: ASCII coding only on handshaked buffers; free-format is binary.
// RL4: Lengths count words when handshaked, bytes when free-format.
// RL5: Limits are 1017 words handshaked and 2046 bytes free-format.
// RL6: Free-format connections refuse vendor and random-access traffic.
// RL7: Open handshaked connections also accept vendor and random-access traffic.
// RL8: Sixteen buffers, each with remote node, direction and mode.
// RL9: Software changes a TCP remote node only while not open.
// RL10: Software may change a UDP remote node at any time.
// RL11: A send goes to the remote node set for that buffer.
// RL12: Stored receptions overwrite the connection info with the sender.
// RL13: Data from a sender not in connection info is dropped silently.
// RL14: Unrestricted passive TCP sends and receives using connection info.
// RL15: Broadcast receptions also update connection info with the sender.
// RL16: Exactly the requested number of units is transmitted.
// RL17: Handshaked sends end on the answer, or error on timer expiry.
// RL18: Software waits for the previous handshaked send before a new one.
// RL19: Open settings take effect when the open indication rises.
// RL20: Software checks init done and open before sending.
// RL21: UDP sends finish when internal processing ends; here a handshaked UDP send still waits for the answer.
// RL22: Software retries a failed send by reissuing it.
// RL23: Software avoids pairing open and alive check on changing nodes.
// RL24: Reception status sets on arrival and clears once read.
// RL25: Sends on receive buffers or over-length sends are rejected with error.
// RL26: One handshaked send outstanding; timer restarts each transmission.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module fbm_top import fbm_pkg::*; #(parameter int RESP_CYCLES_P = RESP_CYCLES) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic INIT_DONE_FLAG,
   output logic [NBUF-1:0] OPEN_DONE,
   output fbm_tx_t TX,
   output logic TX_VALID,
   input wire logic TX_READY,
   input wire fbm_rx_t RX,
   input wire logic RX_VALID,
   output logic OTHER_ACCEPT
);
   // ****************************************
   // Declarations
   // ****************************************
   fbm_txst_t st_q;
   fbm_cfg_t cfg_p [NBUF];
   fbm_cfg_t cfg_q [NBUF];
   fbm_node_t peer_q [NBUF];
   fbm_node_t cinfo_q [NBUF];
   logic [10:0] rx_len_q [NBUF];
   logic [NBUF-1:0] open_q, open_prev_q, rx_stat_q, ack_pend_q;
   logic [3:0] sel_q, tx_buf_q, rx_buf_q;
   logic [MAW-1:0] mem_addr_q, mem_waddr, mem_raddr;
   logic [DW-1:0] mem_wdata, mem_rdata;
   logic [10:0] tx_words_q, tx_idx_q, tx_len_q, rx_cnt_q;
   logic [1:0] rd_cnt_q, err_code_q;
   logic init_q, done_q, err_q, rx_frame_q, rx_acc_q, other_q;
   logic [31:0] rdata_q;
   fbm_tx_t tx_q;
   logic wr_go, rd_go, host_mem_rd, mem_we, rx_we, expired;
   logic send_cmd, send_ok, ack_cmd, ack_go, resp_hit, frame_end;
   logic rx_first, rx_ok, rx_take, rx_store, rx_end_ok;
   logic [3:0] sb, rx_c, ab;
   logic [10:0] slen, rx_units;
   logic [11:0] rx_bytes;

   // ****************************************
   // Avalon slave
   // ****************************************
   // Reads take two wait cycles so buffer words can come from the memory register
   assign AVS_WAITREQUEST = (AVS_READ && rd_cnt_q != RD_LAST) || (AVS_WRITE && mem_we && rx_we);
   assign wr_go = AVS_WRITE && !AVS_WAITREQUEST;
   assign rd_go = AVS_READ && !AVS_WAITREQUEST;
   assign host_mem_rd = AVS_READ && rd_cnt_q == 2'h0 && AVS_ADDRESS == REG_MEM_DATA;
   assign AVS_READDATA = rdata_q;

   // Read wait counter
   always_ff @(posedge CLK_SYS) begin
      if (RESET || !AVS_READ || rd_go) begin
         rd_cnt_q <= 2'h0;
      end else begin
         rd_cnt_q <= rd_cnt_q + 2'h1;
      end
   end

   // Read data, captured one cycle before the answer
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         rdata_q <= '0;
      end else if (AVS_READ && rd_cnt_q == 2'h1) begin
         unique case (AVS_ADDRESS)
            REG_STATUS: rdata_q <= {26'h0, err_code_q, err_q, done_q, (st_q != TX_IDLE), init_q};
            REG_OPEN: rdata_q <= {16'h0, open_q};
            REG_SEL: rdata_q <= {28'h0, sel_q};
            REG_CFG: rdata_q <= {27'h0, cfg_p[sel_q]};
            REG_PEER_IP: rdata_q <= peer_q[sel_q].ip;
            REG_PEER_PORT: rdata_q <= {16'h0, peer_q[sel_q].port};
            REG_CINFO_IP: rdata_q <= cinfo_q[sel_q].ip;
            REG_CINFO_PORT: rdata_q <= {16'h0, cinfo_q[sel_q].port};
            REG_RX_STAT: rdata_q <= {16'h0, rx_stat_q};
            REG_RX_LEN: rdata_q <= {21'h0, rx_len_q[sel_q]};
            REG_MEM_ADDR: rdata_q <= {18'h0, mem_addr_q};
            REG_MEM_DATA: rdata_q <= {16'h0, mem_rdata};
            default: rdata_q <= '0;
         endcase
      end
   end

   // Plain control registers; peer may change any time, TCP users wait for close
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         init_q <= 1'b0;
         open_q <= '0;
         sel_q <= '0;
         mem_addr_q <= '0;
         for (int i = 0; i < NBUF; i++) begin
            cfg_p[i] <= CFG_RST;
            peer_q[i] <= '0;
         end
      end else begin
         if (wr_go && AVS_ADDRESS == REG_INIT) init_q <= AVS_WRITEDATA[0];
         if (wr_go && AVS_ADDRESS == REG_OPEN) open_q <= AVS_WRITEDATA[NBUF-1:0];
         if (wr_go && AVS_ADDRESS == REG_SEL) sel_q <= AVS_WRITEDATA[3:0];
         if (wr_go && AVS_ADDRESS == REG_CFG) cfg_p[sel_q] <= AVS_WRITEDATA[4:0]; // RL8
         if (wr_go && AVS_ADDRESS == REG_PEER_IP) peer_q[sel_q].ip <= AVS_WRITEDATA; // RL10
         if (wr_go && AVS_ADDRESS == REG_PEER_PORT) peer_q[sel_q].port <= AVS_WRITEDATA[15:0];
         // Auto-increment lets software stream a buffer through one window
         if (wr_go && AVS_ADDRESS == REG_MEM_ADDR) begin
            mem_addr_q <= AVS_WRITEDATA[MAW-1:0];
         end else if ((wr_go || rd_go) && AVS_ADDRESS == REG_MEM_DATA) begin
            mem_addr_q <= mem_addr_q + 14'h1;
         end
      end
   end
   assign INIT_DONE_FLAG = init_q;
   assign OPEN_DONE = open_q;

   // Settings become active only on the rising open indication
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         open_prev_q <= '0;
         for (int i = 0; i < NBUF; i++) cfg_q[i] <= CFG_RST;
      end else begin
         open_prev_q <= open_q;
         for (int i = 0; i < NBUF; i++) begin
            if (open_q[i] && !open_prev_q[i]) cfg_q[i] <= cfg_p[i]; // RL19
         end
      end
   end

   // ****************************************
   // Buffer memory
   // ****************************************
   // Reception owns the write port; a clashing host write waits
   assign mem_we = rx_we || (AVS_WRITE && AVS_ADDRESS == REG_MEM_DATA);
   assign mem_waddr = rx_we ? {rx_c, rx_cnt_q[9:0]} : mem_addr_q;
   assign mem_wdata = rx_we ? RX.data : AVS_WRITEDATA[15:0];
   assign mem_raddr = host_mem_rd ? mem_addr_q : {tx_buf_q, tx_idx_q[9:0]};

   fbm_mem u_mem (
      .clk(CLK_SYS),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // ****************************************
   // Receive path
   // ****************************************
   assign rx_first = RX_VALID && !rx_frame_q;
   assign rx_c = rx_first ? RX.conn : rx_buf_q;
   // Sender must match connection info unless unrestricted or broadcast
   assign rx_ok = RX.kind == KIND_FIXED && !RX.resp && open_q[RX.conn] && !cfg_q[RX.conn].send
                  && (RX.src == cinfo_q[RX.conn] || cfg_q[RX.conn].unpassive || RX.bcast); // RL13 RL14
   assign rx_take = RX_VALID && (rx_first ? rx_ok : rx_acc_q);
   assign rx_we = rx_take && !rx_cnt_q[10]; // RL1
   // Units of the frame: words when handshaked, bytes otherwise
   // Byte count kept 12 bits wide so a 1024-beat frame cannot wrap under the limit
   assign rx_bytes = {rx_cnt_q + 11'h1, 1'b0} - {11'h0, RX.half};
   assign rx_units = cfg_q[rx_c].hshake ? rx_cnt_q + 11'h1 : rx_bytes[10:0]; // RL4
   assign rx_end_ok = cfg_q[rx_c].hshake ? rx_cnt_q + 11'h1 <= HS_MAX_WORDS
                      : rx_bytes <= {1'b0, FF_MAX_BYTES}; // RL5
   assign rx_store = rx_take && RX.last && !rx_cnt_q[10] && rx_end_ok;

   // Frame tracking; over-long frames are dropped without status
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         rx_frame_q <= 1'b0;
         rx_acc_q <= 1'b0;
         rx_buf_q <= '0;
         rx_cnt_q <= '0;
      end else if (RX_VALID) begin
         rx_frame_q <= !RX.last;
         if (rx_first) rx_acc_q <= rx_ok;
         if (rx_first) rx_buf_q <= RX.conn;
         rx_cnt_q <= RX.last ? 11'h0 : (rx_take && !rx_cnt_q[10] ? rx_cnt_q + 11'h1 : rx_cnt_q);
      end
   end

   // Reception status; an arrival beats a same-cycle clear
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         rx_stat_q <= '0;
      end else begin
         for (int i = 0; i < NBUF; i++) begin
            if (rx_store && rx_c == 4'(i)) begin
               rx_stat_q[i] <= 1'b1; // RL24
            end else if (wr_go && AVS_ADDRESS == REG_RX_ACK && AVS_WRITEDATA[3:0] == 4'(i)) begin
               rx_stat_q[i] <= 1'b0; // RL24
            end
         end
      end
   end

   // Lengths and connection info of stored receptions
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         for (int i = 0; i < NBUF; i++) begin
            rx_len_q[i] <= '0;
            cinfo_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NBUF; i++) begin
            if (open_q[i] && !open_prev_q[i]) cinfo_q[i] <= peer_q[i];
         end
         if (rx_store) begin
            rx_len_q[rx_c] <= rx_units;
            cinfo_q[rx_c] <= RX.src; // RL12 RL15
         end
      end
   end

   // Vendor and random traffic only rides open handshaked connections
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         other_q <= 1'b0;
      end else begin
         other_q <= rx_first && RX.kind != KIND_FIXED && open_q[RX.conn] && cfg_q[RX.conn].hshake; // RL6 RL7
      end
   end
   assign OTHER_ACCEPT = other_q;

   // Answers owed for read handshaked receptions
   assign ack_cmd = wr_go && AVS_ADDRESS == REG_RX_ACK && cfg_q[AVS_WRITEDATA[3:0]].hshake;
   always_comb begin
      ab = '0;
      for (int i = NBUF - 1; i >= 0; i--) begin
         if (ack_pend_q[i]) ab = 4'(i);
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         ack_pend_q <= '0;
      end else begin
         if (ack_go) ack_pend_q[ab] <= 1'b0;
         if (ack_cmd) ack_pend_q[AVS_WRITEDATA[3:0]] <= 1'b1; // RL2
      end
   end

   // ****************************************
   // Send engine
   // ****************************************
   assign sb = AVS_WRITEDATA[3:0];
   assign slen = AVS_WRITEDATA[SEND_LEN_LSB+10:SEND_LEN_LSB];
   assign send_cmd = wr_go && AVS_ADDRESS == REG_SEND;
   // Busy engine also refuses, keeping one send outstanding
   assign send_ok = st_q == TX_IDLE && init_q && open_q[sb] && cfg_q[sb].send && slen != 11'h0
                    && slen <= (cfg_q[sb].hshake ? HS_MAX_WORDS : FF_MAX_BYTES); // RL25 RL26 RL5
   assign ack_go = st_q == TX_IDLE && !send_cmd && ack_pend_q != '0;
   assign resp_hit = RX_VALID && RX.resp && RX.conn == tx_buf_q;
   assign frame_end = st_q == TX_SEND && TX_READY && tx_q.last;
   assign TX = tx_q;
   assign TX_VALID = st_q == TX_SEND || st_q == TX_ACK;

   fbm_timer #(.CYCLES(RESP_CYCLES_P)) u_timer (
      .clk(CLK_SYS),
      .rst(RESET),
      .start(frame_end && cfg_q[tx_buf_q].hshake),
      .stop(st_q == TX_RESP && resp_hit),
      .expired(expired)
   );

   // Send state machine; free-format ends on internal completion even on UDP
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         st_q <= TX_IDLE;
         tx_q <= '0;
         tx_buf_q <= '0;
         tx_idx_q <= '0;
         tx_words_q <= '0;
         tx_len_q <= '0;
      end else begin
         unique case (st_q)
            TX_IDLE: begin
               if (send_cmd && send_ok) begin
                  tx_buf_q <= sb;
                  tx_len_q <= slen;
                  tx_words_q <= fbm_words(slen, cfg_q[sb].hshake); // RL4
                  tx_idx_q <= '0;
                  tx_q.node <= cfg_q[sb].unpassive ? cinfo_q[sb] : peer_q[sb]; // RL11 RL14
                  tx_q.resp <= 1'b0;
                  tx_q.ascii <= cfg_q[sb].hshake && cfg_q[sb].ascii; // RL3
                  st_q <= TX_FETCH;
               end else if (ack_go) begin
                  tx_q <= '{node: cinfo_q[ab], data: '0, last: 1'b1, half: 1'b0, resp: 1'b1,
                            ascii: cfg_q[ab].ascii};
                  st_q <= TX_ACK;
               end
            end
            TX_FETCH: if (!host_mem_rd) st_q <= TX_WAIT;
            TX_WAIT: begin
               tx_q.data <= mem_rdata;
               tx_q.last <= tx_idx_q == tx_words_q - 11'h1; // RL16
               tx_q.half <= tx_idx_q == tx_words_q - 11'h1 && !cfg_q[tx_buf_q].hshake && tx_len_q[0];
               st_q <= TX_SEND;
            end
            TX_SEND: begin
               if (TX_READY && tx_q.last) begin
                  st_q <= cfg_q[tx_buf_q].hshake ? TX_RESP : TX_IDLE; // RL17 RL21
               end else if (TX_READY) begin
                  tx_idx_q <= tx_idx_q + 11'h1;
                  st_q <= TX_FETCH;
               end
            end
            TX_RESP: if (resp_hit || expired) st_q <= TX_IDLE; // RL17
            TX_ACK: if (TX_READY) st_q <= TX_IDLE;
            default: st_q <= TX_IDLE;
         endcase
      end
   end

   // Sticky send outcome; a new event beats a same-cycle clear
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
         err_code_q <= ERR_NONE;
      end else begin
         if (wr_go && AVS_ADDRESS == REG_STATUS && AVS_WRITEDATA[ST_DONE]) done_q <= 1'b0;
         if (wr_go && AVS_ADDRESS == REG_STATUS && AVS_WRITEDATA[ST_ERR]) err_q <= 1'b0;
         if ((frame_end && !cfg_q[tx_buf_q].hshake) || (st_q == TX_RESP && resp_hit)) done_q <= 1'b1;
         if (send_cmd && !send_ok) begin
            err_q <= 1'b1; // RL25
            err_code_q <= ERR_REJECT;
         end else if (st_q == TX_RESP && expired && !resp_hit) begin
            err_q <= 1'b1; // RL17
            err_code_q <= ERR_TIMEOUT;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   sequence s_last_word;
      st_q == TX_SEND && TX_READY && tx_q.last;
   endsequence
   sequence s_resp_lost;
      st_q == TX_RESP && expired && !resp_hit;
   endsequence

   a_rx_status_set: assert property (rx_store |=> rx_stat_q[$past(rx_c)]) // RL24
      else $error("reception status not set");
   a_send_units: assert property (s_last_word |-> tx_idx_q == tx_words_q - 11'h1) // RL16
      else $error("wrong unit count sent");
   a_free_no_answer: assert property (st_q == TX_ACK |-> cfg_q[$past(ab)].hshake || $past(st_q) == TX_ACK) // RL2
      else $error("answer on free-format buffer");
   a_free_binary: assert property (TX_VALID && !tx_q.resp |-> !tx_q.ascii || cfg_q[tx_buf_q].hshake) // RL3
      else $error("ascii on free-format buffer");
   a_reject_error: assert property (send_cmd && !send_ok |=> err_q && err_code_q == ERR_REJECT) // RL25
      else $error("bad send not flagged");
   a_resp_timeout: assert property (s_resp_lost |=> err_q && err_code_q == ERR_TIMEOUT && st_q == TX_IDLE) // RL17
      else $error("timeout not flagged");
   a_wait_answer: assert property (s_last_word ##0 cfg_q[tx_buf_q].hshake |=> st_q == TX_RESP) // RL26
      else $error("no wait for answer");
   a_open_latch: assert property (!(open_q[0] && !open_prev_q[0]) |=> $stable(cfg_q[0])) // RL19
      else $error("settings changed outside open");
   a_drop_foreign: assert property (rx_first && !rx_ok |-> !rx_we) // RL13
      else $error("foreign data stored");
   a_rx_limit: assert property (rx_store |-> rx_units <= FF_MAX_BYTES) // RL5
      else $error("over-limit reception stored");
endmodule : fbm_top

// file: core/fbm_pkg.sv
package fbm_pkg;
   // ****************************************
   // Sizes and limits
   // ****************************************
   localparam int NBUF = 16;
   localparam int MAW = 14;
   localparam int DW = 16;
   localparam logic [10:0] HS_MAX_WORDS = 11'd1017;
   localparam logic [10:0] FF_MAX_BYTES = 11'd2046;
   localparam logic [10:0] BUF_WORDS = 11'h400;
   // Response monitor time, with cycle count derived from the clock rate
   localparam int RESP_TIME_US = 1000;
   localparam int CLK_MHZ = 100;
   localparam int RESP_CYCLES = RESP_TIME_US * CLK_MHZ;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_INIT = 8'h04;
   localparam logic [7:0] REG_OPEN = 8'h08;
   localparam logic [7:0] REG_SEL = 8'h0c;
   localparam logic [7:0] REG_CFG = 8'h10;
   localparam logic [7:0] REG_PEER_IP = 8'h14;
   localparam logic [7:0] REG_PEER_PORT = 8'h18;
   localparam logic [7:0] REG_CINFO_IP = 8'h1c;
   localparam logic [7:0] REG_CINFO_PORT = 8'h20;
   localparam logic [7:0] REG_SEND = 8'h24;
   localparam logic [7:0] REG_RX_STAT = 8'h28;
   localparam logic [7:0] REG_RX_LEN = 8'h2c;
   localparam logic [7:0] REG_RX_ACK = 8'h30;
   localparam logic [7:0] REG_MEM_ADDR = 8'h34;
   localparam logic [7:0] REG_MEM_DATA = 8'h38;
   // Field positions
   localparam int ST_INIT = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_DONE = 2;
   localparam int ST_ERR = 3;
   localparam int ST_CODE = 4;
   localparam int SEND_LEN_LSB = 16;
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_REJECT = 2'h1;
   localparam logic [1:0] ERR_TIMEOUT = 2'h2;
   localparam logic [1:0] RD_LAST = 2'h2;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {KIND_FIXED = 2'h0, KIND_VENDOR = 2'h1, KIND_RANDOM = 2'h2} fbm_kind_t;
   typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_FETCH = 3'h1, TX_WAIT = 3'h3, TX_SEND = 3'h2,
                             TX_RESP = 3'h6, TX_ACK = 3'h7} fbm_txst_t;
   typedef struct packed {logic [31:0] ip; logic [15:0] port;} fbm_node_t;
   // send: 1 = send buffer; hshake: 1 = handshaked; unpassive: any remote accepted
   typedef struct packed {logic send; logic hshake; logic ascii; logic udp; logic unpassive;} fbm_cfg_t;
   typedef struct packed {fbm_node_t node; logic [15:0] data; logic last; logic half;
                          logic resp; logic ascii;} fbm_tx_t;
   typedef struct packed {fbm_node_t src; logic [3:0] conn; logic [15:0] data; logic last;
                          logic half; logic resp; logic bcast; fbm_kind_t kind;} fbm_rx_t;
   localparam fbm_cfg_t CFG_RST = '0;

   // Words occupied by a length: words when handshaked, bytes otherwise
   function automatic logic [10:0] fbm_words(input logic [10:0] len, input logic hs);
      logic [11:0] w;
      w = {1'b0, len} + 12'h001;
      return hs ? len : w[11:1];
   endfunction : fbm_words
endpackage : fbm_pkg

// file: core/fbm_mem.sv
`timescale 1ns/1ps
// ****************************************
// Fixed buffer storage, registered read
// ****************************************
module fbm_mem import fbm_pkg::*; (
   input wire logic clk,
   input wire logic we,
   input wire logic [MAW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [MAW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<MAW)-1];

   // No reset on the array; contents are defined only after a write
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : fbm_mem

// file: core/fbm_timer.sv
`timescale 1ns/1ps
// ****************************************
// Response monitor timer
// ****************************************
module fbm_timer import fbm_pkg::*; #(parameter int CYCLES = RESP_CYCLES) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic stop,
   output logic expired
);
   logic [31:0] cnt_q;

   // Start reloads, so each transmission gets a full window
   always_ff @(posedge clk) begin
      if (rst || stop) begin
         cnt_q <= '0;
      end else if (start) begin
         cnt_q <= 32'(CYCLES);
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 32'h1;
      end
   end
   assign expired = (cnt_q == 32'h1) && !stop;
endmodule : fbm_timer

// file: testbench/fbm_remote.sv
`timescale 1ns/1ps
// ****************************************
// Remote node model on the link side
// ****************************************
module fbm_remote import fbm_pkg::*; (
   input wire logic clk,
   input wire logic answer_en,
   input wire fbm_tx_t tx,
   input wire logic tx_valid,
   output logic tx_ready,
   output fbm_rx_t rx,
   output logic rx_valid,
   output int words,
   output fbm_tx_t last_word
);
   integer seed = 32'hf30cf310;
   initial begin
      tx_ready = 1'b0;
      rx = '0;
      rx_valid = 1'b0;
      words = 0;
   end
   // Random stalls; idle lines toggle so a stale value is never mistaken for data
   always @(posedge clk) begin
      tx_ready <= ($random(seed) & 1) != 0;
      rx_valid <= 1'b0;
      rx <= ~rx;
      if (tx_valid && tx_ready) begin
         words <= words + 1;
         last_word <= tx;
         if (tx.last && !tx.resp && answer_en) begin
            rx_valid <= 1'b1;
            rx <= '{src: tx.node, conn: 4'h0, data: 16'h0, last: 1'b1, half: 1'b0, resp: 1'b1, bcast: 1'b0,
                    kind: KIND_FIXED};
         end
      end
   end
endmodule : fbm_remote

// file: testbench/tb_fbm_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin err_total++; $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
// ****************************************
// Bench for the fixed buffer engine
// ****************************************
module tb_fbm_top import fbm_pkg::*;;
   logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, rxv_b = 1'b0, answer_en = 1'b1;
   logic [7:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, rdata, s;
   logic wreq, init_flag, txv, txr, rxv_m, other;
   logic [NBUF-1:0] open_done;
   logic [15:0] d;
   fbm_tx_t tx, last_word;
   fbm_rx_t rx_b = '0, rx_m;
   int err_total = 0, checks = 0, words, w0, len;
   integer seed = 32'hf30cf310;
   fbm_top #(.RESP_CYCLES_P(20)) fbm_top_i (.CLK_SYS(clk), .RESET(rst), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .INIT_DONE_FLAG(init_flag), .OPEN_DONE(open_done), .TX(tx), .TX_VALID(txv),
      .TX_READY(txr), .RX(rxv_m ? rx_m : rx_b), .RX_VALID(rxv_m | rxv_b), .OTHER_ACCEPT(other));
   fbm_remote fbm_remote_i (.clk(clk), .answer_en(answer_en), .tx(tx), .tx_valid(txv), .tx_ready(txr),
      .rx(rx_m), .rx_valid(rxv_m), .words(words), .last_word(last_word));
   initial forever #5 clk = ~clk;
   // Bus cycle: request held until the rising edge that samples waitrequest low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      while (wreq !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      q = rdata;
      if (wreq !== 1'b0) begin err_total++; finish_test(); end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] q;
      bus(1'b1, a, wd, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask : rd
   // Poll until done or error, bounded
   task automatic wait_st(output logic [31:0] q);
      int n;
      n = 0;
      q = '0;
      while (q[ST_DONE] !== 1'b1 && q[ST_ERR] !== 1'b1 && n < 200) begin rd(REG_STATUS, q); n++; end
      if (n >= 200) begin err_total++; finish_test(); end
   endtask : wait_st
   // Receive frame from a given source into buffer c; odd byte on the last beat
   task automatic frame(input fbm_node_t src, input int n, input logic bc, input logic [3:0] c);
      for (int i = 0; i < n; i++) begin
         rx_b <= '{src: src, conn: c, data: 16'(i), last: i == n - 1, half: i == n - 1, resp: 1'b0,
                   bcast: bc, kind: KIND_FIXED};
         rxv_b <= 1'b1;
         @(posedge clk);
      end
      rxv_b <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : frame
   task automatic finish_test();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("init", 1'b0, init_flag)
      wr(REG_INIT, 32'h1);
      `CHK("init", 1'b1, init_flag)
      wr(REG_CFG, 32'h1c);
      wr(REG_PEER_IP, 32'h0a000001);
      wr(REG_PEER_PORT, 32'h1388);
      wr(REG_SEL, 32'h1);
      wr(REG_CFG, 32'h02);
      wr(REG_PEER_IP, 32'h0a000002);
      wr(REG_PEER_PORT, 32'h1389);
      wr(REG_OPEN, 32'h3);
      `CHK("open", 16'h3, open_done)
      rd(REG_CINFO_IP, s);
      `CHK("cinfo", 32'h0a000002, s)
      // Handshaked sends of random length, then a one-word send that goes unanswered
      for (int k = 0; k < 4; k++) begin
         len = (k == 3) ? 1 : 1 + ($random(seed) & 7);
         answer_en <= (k < 3);
         wr(REG_MEM_ADDR, 32'h0);
         for (int i = 0; i < len; i++) begin d = 16'($random(seed)); wr(REG_MEM_DATA, {16'h0, d}); end
         w0 = words;
         wr(REG_SEND, len << 16);
         wait_st(s);
         `CHK("sent", len, words - w0)
         `CHK("node", {32'h0a000001, 16'h1388}, last_word.node)
         `CHK("data", d, last_word.data)
         `CHK("ascii", 1'b1, last_word.ascii)
         `CHK("stat", (k < 3) ? 6'h05 : 6'h29, s[5:0])
         wr(REG_STATUS, 32'hc);
      end
      // Over-length send, then a send on a receive buffer
      for (int k = 0; k < 2; k++) begin
         wr(REG_SEND, k ? 32'h00010001 : {5'h0, HS_MAX_WORDS + 11'd1, 16'h0});
         wait_st(s);
         `CHK("reject", 6'h19, s[5:0])
         wr(REG_STATUS, 32'hc);
      end
      frame({32'h0a000002, 16'h1389}, 3, 1'b0, 4'h1);
      rd(REG_RX_STAT, s);
      `CHK("rxstat", 32'h2, s)
      rd(REG_RX_LEN, s);
      `CHK("rxlen", 32'h5, s)
      w0 = words;
      wr(REG_RX_ACK, 32'h1);
      rd(REG_RX_STAT, s);
      `CHK("rxack", 32'h0, s)
      `CHK("noanswer", w0, words)
      frame({32'h0a000009, 16'h1389}, 2, 1'b0, 4'h1);
      rd(REG_RX_STAT, s);
      `CHK("drop", 32'h0, s)
      frame({32'h0a000009, 16'h1390}, 2, 1'b1, 4'h1);
      rd(REG_CINFO_IP, s);
      `CHK("bcast", 32'h0a000009, s)
      // Handshaked reception on buffer 2 is answered after its acknowledge
      wr(REG_SEL, 32'h2);
      wr(REG_CFG, 32'h08);
      wr(REG_OPEN, 32'h7);
      frame({32'h0, 16'h0}, 2, 1'b0, 4'h2);
      w0 = words;
      wr(REG_RX_ACK, 32'h2);
      for (int i = 0; i < 40 && words == w0; i++) @(posedge clk);
      `CHK("answer", w0 + 1, words)
      `CHK("resp", 1'b1, last_word.resp)
      // Vendor traffic is accepted on handshaked buffer 0 and refused on free-format buffer 1
      for (int k = 0; k < 2; k++) begin
         rx_b <= '{src: '0, conn: 4'(k), data: 16'h0, last: 1'b1, half: 1'b0, resp: 1'b0, bcast: 1'b0,
                   kind: KIND_VENDOR};
         rxv_b <= 1'b1;
         @(posedge clk);
         rxv_b <= 1'b0;
         @(posedge clk);
         `CHK("other", k == 0, other)
      end
      finish_test();
   end
endmodule : tb_fbm_top
